// [rst_seq_map.svh]
`ifndef RST_SEQ_MAP_SVH
`define RST_SEQ_MAP_SVH

// register byte offsets
`define RS_OFS_CAUSE     8'h00
`define RS_OFS_OSC       8'h04
`define RS_OFS_RTC       8'h08
`define RS_OFS_FLASH     8'h0c
`define RS_OFS_STAT      8'h10

// reset_cause_control field positions
`define RS_B_TRAP        15
`define RS_B_ILLOP       14
`define RS_B_CM          9
`define RS_B_VREGS       8
`define RS_B_PIN         7
`define RS_B_SOFT        6
`define RS_B_SWDTEN      5
`define RS_B_WATCHDOG_TIMEOUT_FLAG        4
`define RS_B_SLEEP       3
`define RS_B_IDLE        2
`define RS_B_BOR         1
`define RS_B_POR         0
`define RS_CAUSE_MASK    16'hc3ff
`define RS_CAUSE_POR     16'h0003

// osc_control_reg fields
`define RS_OSC_CUR_LSB   12
`define RS_OSC_NEW_LSB   8
`define RS_OSC_POR       3'h0

// power-on-only registers
`define RS_RTC_POR       16'h0000
`define RS_FLASH_POR     16'h0000

`define RS_RESET_VECTOR  24'h000000

// timing, in ns, and cycle counts rounded up
`define RS_CLK_NS        20
`define RS_POWERON_DELAY_NS       10000
`define RS_REGULATOR_DELAY_NS      10000
`define RS_TPWRT_NS      64000000
`define RS_TRST_NS       32000
`define RS_MONITOR_START_DELAY_NS      100000
`define RS_CYC(ns)       (((ns) + `RS_CLK_NS - 1) / `RS_CLK_NS)
`define RS_POWERON_DELAY_CYC      `RS_CYC(`RS_POWERON_DELAY_NS)
`define RS_REGULATOR_DELAY_CYC     `RS_CYC(`RS_REGULATOR_DELAY_NS)
`define RS_TPWRT_CYC     `RS_CYC(`RS_TPWRT_NS)
`define RS_TRST_CYC      `RS_CYC(`RS_TRST_NS)
`define RS_MONITOR_START_DELAY_CYC     `RS_CYC(`RS_MONITOR_START_DELAY_NS)

// start-up timer of crystal sources, and sequencer and monitor counter widths
`define RS_OST_PERIODS   1024
`define RS_OST_W         10
`define RS_SEQ_W         22
`define RS_MON_W         13

`endif

// [rst_seq_pkg.sv]
package rst_seq_pkg;

    typedef enum logic [4:0] {
        ST_HOLD  = 5'b00001,
        ST_POR   = 5'b00010,
        ST_START = 5'b00100,
        ST_ISR   = 5'b01000,
        ST_RUN   = 5'b10000
    } seq_state_t;

    typedef enum logic [1:0] {
        KIND_POR   = 2'b00,
        KIND_BOR   = 2'b01,
        KIND_OTHER = 2'b10
    } rst_kind_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic brownout;
        logic master_clear_pin_n;
        logic soft_reset;
        logic watchdog_timeout;
        logic config_mismatch;
        logic trap_conflict;
        logic illegal_op;
    } rst_src_t;

    typedef struct packed {
        logic       clk_switch_en;
        logic [2:0] new_osc_select_cfg;
        logic       regulator_en;
        logic       monitor_en;
        logic       osc_is_crystal;
        logic       osc_uses_pll;
    } osc_cfg_t;

endpackage

// [cycle_timer.sv]
`timescale 1ns/100ps

// runs for load_value+1 ticks after start; done while idle
module cycle_timer #(
    parameter int W = 16
) (
    input  wire logic         mclk,
    input  wire logic         arst_n,
    input  wire logic         start,
    input  wire logic         tick,
    input  wire logic [W-1:0] load_value,
    output logic              done
);
    typedef struct packed {
        logic         run;
        logic [W-1:0] cnt;
    } tmr_t;

    tmr_t s;
    tmr_t next_s;

    always_comb begin
        next_s = s;
        if (start) begin
            next_s.run = 1'b1;
            next_s.cnt = load_value;
        end else if (s.run && tick) begin
            if (s.cnt == '0) begin
                next_s.run = 1'b0;
            end else begin
                next_s.cnt = s.cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign done = ~s.run;
endmodule // cycle_timer

// [reset_flags_and_delay_sequencer.sv]
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
// Function
// - trap, illegal-op, mismatch flags: set, cleared by POR or software write
// - software reads and writes every cause flag
// - switching on: POR/BOR config bits, else current
// - switching off: always the configured oscillator
// - release reset after POR and startup delays
// - start-up timer and PLL lock run concurrently
// - POR delay is POR+startup+internal reset
// - startup is regulator delay or power-up timer
// - every reset includes internal reset interval
// - crystal: count 1024 oscillator periods first
// - no execution before clock is released
// - monitor after release; fail switches, traps
// - crystal/PLL: 100 us before monitoring starts
// - only cause and osc resets depend on type
// - rtc and flash registers cleared by POR only
// - any reset clears fetch address to zero
// - reset never goes through interrupt controller
// - any active source asserts system reset
// - POR clears flags, sets brownout and power-on
// - software flag writes never cause reset
`include "rst_seq_map.svh"

module reset_flags_and_delay_sequencer
    import rst_seq_pkg::*;
#(
    parameter int         POWERUP_TIMER_CYCLES   = `RS_TPWRT_CYC,
    parameter int         CLOCK_FAIL_MONITOR_CYCLES   = `RS_MONITOR_START_DELAY_CYC,
    parameter int         SEQ_W         = `RS_SEQ_W,
    parameter int         MON_W         = `RS_MON_W,
    parameter logic [2:0] FAST_OSC_CODE = 3'h0
) (
    input  wire logic     mclk,
    input  wire logic     arst_n,
    input  wire apb_req_t apb_req,
    output apb_rsp_t      apb_rsp,
    input  wire rst_src_t rst_src,
    input  wire logic     power_save_sleep,
    input  wire logic     power_save_idle,
    input  wire osc_cfg_t osc_cfg,
    input  wire logic     osc_tick,
    input  wire logic     pll_locked,
    input  wire logic     osc_clock_valid,
    output logic          system_reset,
    output logic          cpu_run,
    output logic          fetch_start,
    output logic [23:0]   fetch_addr,
    output logic [2:0]    clock_source,
    output logic          osc_fail_trap
);
    typedef struct packed {
        seq_state_t  st;
        rst_kind_t   kind;
        logic [15:0] cause;
        logic [2:0]  cur_osc;
        logic [2:0]  new_osc_req;
        logic [15:0] rtc_cal;
        logic [15:0] flash_ctl;
        logic        mon_pending;
        logic        mon_active;
        logic        fail_trap;
        logic        run_q;
        logic        fetch_go;
        logic [23:0] fetch_pc;
        logic [31:0] prdata;
    } top_t;

    localparam top_t RESET_STATE = '{
        st:          ST_HOLD,
        kind:        KIND_POR,
        cause:       `RS_CAUSE_POR,
        cur_osc:     `RS_OSC_POR,
        new_osc_req: `RS_OSC_POR,
        rtc_cal:     `RS_RTC_POR,
        flash_ctl:   `RS_FLASH_POR,
        mon_pending: 1'b0,
        mon_active:  1'b0,
        fail_trap:   1'b0,
        run_q:       1'b0,
        fetch_go:    1'b0,
        fetch_pc:    `RS_RESET_VECTOR,
        prdata:      32'h0000_0000
    };

    localparam logic [SEQ_W-1:0] LOAD_POR   = SEQ_W'(`RS_POWERON_DELAY_CYC - 1);
    localparam logic [SEQ_W-1:0] LOAD_VREG  = SEQ_W'(`RS_REGULATOR_DELAY_CYC - 1);
    localparam logic [SEQ_W-1:0] LOAD_POWERUP_TIMER  = SEQ_W'(POWERUP_TIMER_CYCLES - 1);
    localparam logic [SEQ_W-1:0] LOAD_RST   = SEQ_W'(`RS_TRST_CYC - 1);
    localparam logic [MON_W-1:0] LOAD_CLOCK_FAIL_MONITOR  = MON_W'(CLOCK_FAIL_MONITOR_CYCLES - 1);
    localparam logic [`RS_OST_W-1:0] LOAD_OST = `RS_OST_W'(`RS_OST_PERIODS - 1);

    top_t s;
    top_t next_s;

    logic             any_src;
    logic             seq_start;
    logic [SEQ_W-1:0] seq_load;
    logic             seq_done;
    logic             mon_start;
    logic             mon_done;
    logic             ost_start;
    logic             ost_done;
    logic             clock_released;
    logic [SEQ_W-1:0] startup_load;
    logic             apb_wr;
    logic             apb_setup;
    logic             mapped;
    logic [31:0]      rd_mux;

    // delays run on mclk, which stays up whatever oscillator the core picks
    cycle_timer #(.W(SEQ_W)) seq_timer (
        .mclk       (mclk),
        .arst_n     (arst_n),
        .start      (seq_start),
        .tick       (1'b1),
        .load_value (seq_load),
        .done       (seq_done)
    );

    cycle_timer #(.W(MON_W)) mon_timer (
        .mclk       (mclk),
        .arst_n     (arst_n),
        .start      (mon_start),
        .tick       (1'b1),
        .load_value (LOAD_CLOCK_FAIL_MONITOR),
        .done       (mon_done)
    );

    // counts oscillator periods, 10-bit, 1024 of them
    cycle_timer #(.W(`RS_OST_W)) ost_timer (
        .mclk       (mclk),
        .arst_n     (arst_n),
        .start      (ost_start),
        .tick       (osc_tick & osc_cfg.osc_is_crystal),
        .load_value (LOAD_OST),
        .done       (ost_done)
    );

    // any active source holds reset
    assign any_src = rst_src.brownout | ~rst_src.master_clear_pin_n
                   | rst_src.soft_reset | rst_src.watchdog_timeout
                   | rst_src.config_mismatch | rst_src.trap_conflict
                   | rst_src.illegal_op;

    // regulator delay or power-up timer
    assign startup_load = osc_cfg.regulator_en ? LOAD_VREG : LOAD_POWERUP_TIMER;

    // oscillator restarts only on power events; it counts beside the reset delay
    assign ost_start = (s.st == ST_HOLD) && (s.kind != KIND_OTHER);

    // pll lock is waited for in parallel, not after release
    assign clock_released = (~osc_cfg.osc_is_crystal | ost_done)
                          & (~osc_cfg.osc_uses_pll | pll_locked);

    assign apb_wr    = apb_req.psel & apb_req.penable & apb_req.pwrite;
    assign apb_setup = apb_req.psel & ~apb_req.penable;

    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        case (apb_req.paddr)
            `RS_OFS_CAUSE: rd_mux = {16'h0000, s.cause};
            `RS_OFS_OSC:   rd_mux = {16'h0000, 1'b0, s.cur_osc, 1'b0,
                                     s.new_osc_req, 8'h00};
            `RS_OFS_RTC:   rd_mux = {16'h0000, s.rtc_cal};
            `RS_OFS_FLASH: rd_mux = {16'h0000, s.flash_ctl};
            `RS_OFS_STAT:  rd_mux = {22'h000000, s.st, s.kind, s.mon_active,
                                     clock_released, s.run_q};
            default:       mapped = 1'b0;
        endcase
    end

    always_comb begin
        next_s           = s;
        next_s.fail_trap = 1'b0;
        seq_start        = 1'b0;
        seq_load         = LOAD_RST;
        mon_start        = 1'b0;

        // sequence: each stage waits for the previous one to expire
        case (s.st)
            ST_HOLD: begin
                if (!any_src) begin
                    seq_start = 1'b1;
                    case (s.kind)
                        KIND_POR: begin
                            seq_load  = LOAD_POR;
                            next_s.st = ST_POR;
                        end
                        KIND_BOR: begin
                            seq_load  = startup_load;
                            next_s.st = ST_START;
                        end
                        default: begin
                            seq_load  = LOAD_RST;
                            next_s.st = ST_ISR;
                        end
                    endcase
                end
            end
            ST_POR: begin
                if (seq_done) begin
                    seq_start = 1'b1;
                    seq_load  = startup_load;
                    next_s.st = ST_START;
                end
            end
            ST_START: begin
                if (seq_done) begin
                    seq_start = 1'b1;
                    seq_load  = LOAD_RST;
                    next_s.st = ST_ISR;
                end
            end
            ST_ISR: begin
                if (seq_done) begin
                    next_s.st = ST_RUN;
                    if (osc_cfg.monitor_en) begin
                        if (osc_cfg.osc_is_crystal | osc_cfg.osc_uses_pll) begin
                            mon_start          = 1'b1;
                            next_s.mon_pending = 1'b1;
                        end else begin
                            next_s.mon_active = 1'b1;
                        end
                    end
                end
            end
            ST_RUN: begin
                next_s.st = ST_RUN;
            end
            default: begin
                next_s.st = ST_HOLD;
            end
        endcase

        if (s.mon_pending && mon_done) begin
            next_s.mon_pending = 1'b0;
            next_s.mon_active  = 1'b1;
        end

        // no good clock once watching: fall back to the fast oscillator
        if (s.mon_active && !osc_clock_valid && s.cur_osc != FAST_OSC_CODE) begin
            next_s.cur_osc   = FAST_OSC_CODE;
            next_s.fail_trap = 1'b1;
        end

        if (any_src) begin
            next_s.st          = ST_HOLD;
            next_s.mon_pending = 1'b0;
            next_s.mon_active  = 1'b0;
            if (rst_src.brownout) begin
                next_s.kind = KIND_BOR;
            end else if (s.st == ST_RUN) begin
                next_s.kind = KIND_OTHER;
            end
        end

        // a power kind stays until the full sequence has run
        if (s.st == ST_HOLD || next_s.st == ST_HOLD) begin
            if (!osc_cfg.clk_switch_en) begin
                next_s.cur_osc = osc_cfg.new_osc_select_cfg;
            end else if (next_s.kind != KIND_OTHER) begin
                next_s.cur_osc = osc_cfg.new_osc_select_cfg;
            end
            // pc forced to zero directly, no vector fetch or arbitration
            next_s.fetch_pc = `RS_RESET_VECTOR;
        end

        // core only runs on a released clock, even after reset lifts
        next_s.run_q    = (next_s.st == ST_RUN) & clock_released;
        next_s.fetch_go = next_s.run_q & ~s.run_q;

        // software writes only store status, no reset path from here
        if (apb_wr) begin
            case (apb_req.paddr)
                `RS_OFS_CAUSE: next_s.cause = apb_req.pwdata[15:0] & `RS_CAUSE_MASK;
                `RS_OFS_OSC:   next_s.new_osc_req = apb_req.pwdata[10:8];
                `RS_OFS_RTC:   next_s.rtc_cal = apb_req.pwdata[15:0];
                `RS_OFS_FLASH: next_s.flash_ctl = apb_req.pwdata[15:0];
                default:       next_s.cause = next_s.cause;
            endcase
        end

        // power-save clears the timeout flag; sets below still win
        if (power_save_sleep | power_save_idle) begin
            next_s.cause[`RS_B_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
        end

        // hardware sets come last so an event never loses to a clear
        if (rst_src.trap_conflict)   next_s.cause[`RS_B_TRAP]  = 1'b1;
        if (rst_src.illegal_op)      next_s.cause[`RS_B_ILLOP] = 1'b1;
        if (rst_src.config_mismatch) next_s.cause[`RS_B_CM]    = 1'b1;
        if (!rst_src.master_clear_pin_n) next_s.cause[`RS_B_PIN] = 1'b1;
        if (rst_src.soft_reset)      next_s.cause[`RS_B_SOFT]  = 1'b1;
        if (rst_src.watchdog_timeout) next_s.cause[`RS_B_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
        if (power_save_sleep)        next_s.cause[`RS_B_SLEEP] = 1'b1;
        if (power_save_idle)         next_s.cause[`RS_B_IDLE]  = 1'b1;
        if (rst_src.brownout)        next_s.cause[`RS_B_BOR]   = 1'b1;

        // read data is latched in setup so the access phase needs no wait
        if (apb_setup) begin
            next_s.prdata = rd_mux;
        end
    end

    // only arst_n reloads cause, osc, rtc and flash values
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s <= RESET_STATE;
        end else begin
            s <= next_s;
        end
    end

    assign apb_rsp.prdata  = s.prdata;
    assign apb_rsp.pready  = 1'b1;
    assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~mapped;

    assign system_reset  = any_src | (s.st != ST_RUN);
    assign cpu_run       = s.run_q;
    assign fetch_start   = s.fetch_go;
    assign fetch_addr    = s.fetch_pc;
    assign clock_source  = s.cur_osc;
    assign osc_fail_trap = s.fail_trap;
endmodule // reset_flags_and_delay_sequencer

// [reset_flags_and_delay_sequencer_chk.sv]
`timescale 1ns/100ps
module reset_flags_and_delay_sequencer_chk
    import rst_seq_pkg::*;
#(
    parameter int         POWERUP_TIMER_CYCLES   = 40,
    parameter int         CLOCK_FAIL_MONITOR_CYCLES   = 20,
    parameter logic [2:0] FAST_OSC_CODE = 3'h0
) (
    input wire logic        mclk,
    input wire logic        arst_n,
    input wire apb_req_t    apb_req,
    input wire apb_rsp_t    apb_rsp,
    input wire rst_src_t    rst_src,
    input wire logic        power_save_sleep,
    input wire logic        power_save_idle,
    input wire osc_cfg_t    osc_cfg,
    input wire logic        osc_tick,
    input wire logic        pll_locked,
    input wire logic        osc_clock_valid,
    input wire logic        system_reset,
    input wire logic        cpu_run,
    input wire logic        fetch_start,
    input wire logic [23:0] fetch_addr,
    input wire logic [2:0]  clock_source,
    input wire logic        osc_fail_trap
);
    int   hi_cnt;
    int   lo_cnt;
    int   tick_cnt;
    logic por_pend;
    logic any_src;

    assign any_src = rst_src.brownout | ~rst_src.master_clear_pin_n | rst_src.soft_reset
                   | rst_src.watchdog_timeout | rst_src.config_mismatch
                   | rst_src.trap_conflict | rst_src.illegal_op;

    // ticks counted since power-on only: later resets other than brown-out keep the released clock
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            hi_cnt <= 0;
            lo_cnt <= 0;
            tick_cnt <= 0;
            por_pend <= 1'b1;
        end else begin
            hi_cnt <= system_reset ? hi_cnt + 1 : 0;
            lo_cnt <= system_reset ? 0 : lo_cnt + 1;
            if (osc_tick && tick_cnt < 2000)
                tick_cnt <= tick_cnt + 1;
            if (!system_reset)
                por_pend <= 1'b0;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    sequence access_s;
        apb_req.psel && apb_req.penable;
    endsequence
    sequence launch_s;
        !cpu_run ##1 cpu_run;
    endsequence

    src_holds_a: assert property (any_src |-> system_reset)
        else $error("system reset low while a source is active");
    run_released_a: assert property (cpu_run |-> !system_reset || any_src)
        else $error("cpu running under system reset");
    fetch_zero_a: assert property (launch_s |-> fetch_start && fetch_addr == 24'h000000)
        else $error("fetch not started at address zero");
    fetch_pulse_a: assert property (fetch_start |=> !fetch_start)
        else $error("fetch start longer than one cycle");
    por_time_a: assert property ($fell(system_reset) && por_pend |->
        hi_cnt >= (osc_cfg.regulator_en ? 2600 : 2100 + POWERUP_TIMER_CYCLES))
        else $error("power-on release too early");
    isr_time_a: assert property ($fell(system_reset) |-> hi_cnt >= 1600)
        else $error("release before internal reset interval");
    clk_fixed_a: assert property ($fell(system_reset) && !osc_cfg.clk_switch_en |->
        clock_source == osc_cfg.new_osc_select_cfg)
        else $error("clock source not the configured one");
    fail_fast_a: assert property (osc_fail_trap |->
        clock_source == FAST_OSC_CODE && !$past(osc_clock_valid))
        else $error("fail trap without switch to fast oscillator");
    fail_late_a: assert property (osc_fail_trap && (osc_cfg.osc_is_crystal ||
        osc_cfg.osc_uses_pll) |-> lo_cnt >= CLOCK_FAIL_MONITOR_CYCLES)
        else $error("monitor started before its delay");
    ost_count_a: assert property ($rose(cpu_run) && osc_cfg.osc_is_crystal |->
        tick_cnt >= 1024)
        else $error("crystal released before start-up count");
    sw_write_a: assert property (access_s ##0 apb_req.pwrite && !system_reset
        && !any_src |=> !system_reset)
        else $error("register write caused a reset");
endmodule // reset_flags_and_delay_sequencer_chk

// [test_reset_flags_and_delay_sequencer.sv]
`timescale 1ns/100ps
module test_reset_flags_and_delay_sequencer;
    import rst_seq_pkg::*;
    logic        mclk;
    logic        arst_n;
    apb_req_t    req;
    apb_rsp_t    rsp;
    rst_src_t    src;
    osc_cfg_t    cfg;
    logic        tick_en;
    logic        osc_tick = 1'b0;
    logic        clk_ok;
    logic        pll_ok;
    logic        ps_sleep;
    logic        ps_idle;
    logic        err;
    logic        system_reset;
    logic        cpu_run;
    logic        fetch_start;
    logic [23:0] fetch_addr;
    logic [2:0]  clock_source;
    logic        osc_fail_trap;
    int          bad_count;
    int          cmp_count;
    int          seed;
    int          n;
    int          exp_cause;
    logic [2:0]  exp_clk;
    logic [31:0] rd;
    logic [31:0] v;
    int          bitpos [7] = '{14, 15, 9, 4, 6, 7, 1};

    // short start-up and monitor counts keep the run small
    reset_flags_and_delay_sequencer #(
        .POWERUP_TIMER_CYCLES(40),
        .CLOCK_FAIL_MONITOR_CYCLES(20)
    ) u_reset_flags_and_delay_sequencer (
        .mclk            (mclk),
        .arst_n          (arst_n),
        .apb_req         (req),
        .apb_rsp         (rsp),
        .rst_src         (src),
        .power_save_sleep(ps_sleep),
        .power_save_idle (ps_idle),
        .osc_cfg         (cfg),
        .osc_tick        (osc_tick),
        .pll_locked      (pll_ok),
        .osc_clock_valid (clk_ok),
        .system_reset    (system_reset),
        .cpu_run         (cpu_run),
        .fetch_start     (fetch_start),
        .fetch_addr      (fetch_addr),
        .clock_source    (clock_source),
        .osc_fail_trap   (osc_fail_trap)
    );

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    always @(posedge mclk)
        osc_tick <= tick_en & ~osc_tick;

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge mclk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge mclk);
        req.penable <= 1'b1;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (rsp.pready !== 1'b1 && k < 20);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
        if (rsp.pready !== 1'b1) begin
            chk(0, 1);
            test_done();
        end
    endtask

    // 0: reset released, 1: cpu running, 2: fail trap
    task automatic wait_sig(input int which, input int lim);
        n = 0;
        while (n < lim && (which == 0 ? system_reset !== 1'b0 :
               which == 1 ? cpu_run !== 1'b1 : osc_fail_trap !== 1'b1)) begin
            @(negedge mclk);
            n++;
        end
        if (n == lim) begin
            bad_count++;
            $display("[FAIL] %0t wait ran out", $time);
            test_done();
        end else begin
            // hand back on a rising edge so the next drive lands there
            @(posedge mclk);
        end
    endtask

    // source k held three cycles; pin source is active low
    task automatic hit(input int k);
        @(posedge mclk);
        src <= rst_src_t'(7'h20 ^ (7'h01 << k));
        repeat (3) @(posedge mclk);
        src <= rst_src_t'(7'h20);
    endtask

    initial begin
        seed = 97;
        bad_count = 0;
        cmp_count = 0;
        arst_n = 1'b0;
        req = '0;
        src = rst_src_t'(7'h20);
        cfg = '{1'b1, 3'h5, 1'b1, 1'b0, 1'b0, 1'b0};
        tick_en = 1'b0;
        clk_ok = 1'b1;
        pll_ok = 1'b1;
        ps_sleep = 1'b0;
        ps_idle = 1'b0;
        repeat (6) @(posedge mclk);
        arst_n <= 1'b1;
        wait_sig(0, 4000);
        chk(n >= 2600, 1);
        wait_sig(1, 100);
        apb(0, 8'h00, 0);
        chk(rd, 32'h3);
        apb(0, 8'h08, 0);
        chk(rd, 0);
        chk(clock_source, 3'h5);
        apb(0, 8'h10, 0);
        chk(rd, 32'h203);
        chk(err, 0);
        apb(0, 8'h14, 0);
        chk(rd, 0);
        chk(err, 1);
        $display("test power-on done");
        v = $random(seed);
        apb(1, 8'h00, v);
        apb(0, 8'h00, 0);
        chk(rd, v & 32'hc3ff);
        chk(system_reset, 0);
        apb(1, 8'h08, v);
        apb(1, 8'h0c, ~v);
        apb(1, 8'h00, 0);
        exp_cause = 0;
        exp_clk = 3'h5;
        $display("test software flags done");
        // flags accumulate: none of the seven resets clears them
        for (int k = 0; k < 7; k++) begin
            cfg.new_osc_select_cfg <= 3'($random(seed));
            hit(k);
            wait_sig(0, 4000);
            chk(n >= 1600, 1);
            wait_sig(1, 100);
            if (k == 6)
                exp_clk = cfg.new_osc_select_cfg;
            exp_cause |= 1 << bitpos[k];
            apb(0, 8'h00, 0);
            chk(rd, exp_cause);
            chk(clock_source, exp_clk);
        end
        // power-save pulses mark sleep and idle and drop the timeout flag
        @(posedge mclk);
        ps_sleep <= 1'b1;
        @(posedge mclk);
        ps_sleep <= 1'b0;
        ps_idle <= 1'b1;
        @(posedge mclk);
        ps_idle <= 1'b0;
        apb(0, 8'h00, 0);
        chk(rd, (exp_cause & ~32'h10) | 32'hc);
        apb(0, 8'h08, 0);
        chk(rd, v & 32'hffff);
        apb(0, 8'h0c, 0);
        chk(rd, ~v & 32'hffff);
        $display("test reset sources done");
        cfg.clk_switch_en <= 1'b0;
        cfg.new_osc_select_cfg <= 3'h6;
        hit(4);
        wait_sig(1, 4000);
        chk(clock_source, 3'h6);
        $display("test fixed clock done");
        cfg <= '{1'b1, 3'h3, 1'b1, 1'b1, 1'b1, 1'b1};
        clk_ok <= 1'b0;
        hit(6);
        wait_sig(0, 4000);
        wait_sig(2, 100);
        chk(n >= 20, 1);
        chk(clock_source, 3'h0);
        chk(cpu_run, 0);
        @(posedge mclk);
        clk_ok <= 1'b1;
        tick_en <= 1'b1;
        wait_sig(1, 3000);
        chk(n >= 2000, 1);
        $display("test crystal monitor done");
        cfg.regulator_en <= 1'b0;
        pll_ok <= 1'b0;
        hit(3);
        repeat (50) @(posedge mclk);
        arst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        wait_sig(0, 4000);
        chk(n >= 2140 && n < 2600, 1);
        chk(cpu_run, 0);
        pll_ok <= 1'b1;
        wait_sig(1, 3000);
        apb(0, 8'h00, 0);
        chk(rd, 32'h3);
        apb(0, 8'h08, 0);
        chk(rd, 0);
        $display("test second power-on done");
        test_done();
    end
endmodule // test_reset_flags_and_delay_sequencer

bind reset_flags_and_delay_sequencer reset_flags_and_delay_sequencer_chk #(
    .POWERUP_TIMER_CYCLES  (POWERUP_TIMER_CYCLES),
    .CLOCK_FAIL_MONITOR_CYCLES  (CLOCK_FAIL_MONITOR_CYCLES),
    .FAST_OSC_CODE(FAST_OSC_CODE)
) u_chk (
    .mclk, .arst_n, .apb_req, .apb_rsp, .rst_src, .power_save_sleep, .power_save_idle,
    .osc_cfg, .osc_tick, .pll_locked, .osc_clock_valid, .system_reset, .cpu_run,
    .fetch_start, .fetch_addr, .clock_source, .osc_fail_trap
);
